// >>> input_mapper_pkg.sv
// constants, codes, register map and carrier types of the input function mapper
// assumes one 200 MHz system clock and a software master on APB
package input_mapper_pkg;

   localparam int          NUM_INPUTS = 6;
   localparam int          CODE_W     = 5;
   localparam int          ADDR_W     = 12;

   // ************************************************************
   // function codes
   // ************************************************************
   localparam logic [4:0]  FN_NONE         = 5'h00;
   localparam logic [4:0]  FN_START_STOP   = 5'h01;
   localparam logic [4:0]  FN_START_3W     = 5'h02;
   localparam logic [4:0]  FN_STOP_3W      = 5'h03;
   localparam logic [4:0]  FN_GEN_ENABLE   = 5'h04;
   localparam logic [4:0]  FN_SOURCE       = 5'h05;
   localparam logic [4:0]  FN_JOG          = 5'h06;
   localparam logic [4:0]  FN_DIRECTION    = 5'h07;
   localparam logic [4:0]  FN_EXT_FAULT    = 5'h08;
   localparam logic [4:0]  FN_EXT_ALARM    = 5'h09;
   localparam logic [4:0]  FN_BRAKE        = 5'h0A;
   localparam logic [4:0]  FN_FAULT_RESET  = 5'h0B;
   localparam logic [4:0]  FN_LOAD_USER    = 5'h0C;
   localparam logic [4:0]  FN_EMERGENCY    = 5'h0E;
   localparam logic [4:0]  FN_THERM_ALARM  = 5'h0F;
   localparam logic [4:0]  FN_THERM_FAULT  = 5'h10;
   localparam logic [4:0]  FN_MAX          = 5'h10;

   // input positions with private codes
   localparam int          EMERGENCY_INPUT = 2;
   localparam int          THERMISTOR_INPUT = 5;

   // ************************************************************
   // selector reset values, first input at index 0
   // ************************************************************
   localparam logic [4:0]  SEL_RESET [NUM_INPUTS] = '{5'h02, 5'h03, 5'h00,
                                                     5'h00, 5'h00, 5'h00};

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [11:0] REG_SEL_BASE    = 12'h000;
   localparam logic [11:0] REG_INPUT_STAT  = 12'h018;
   localparam logic [11:0] REG_FUNC_STAT   = 12'h01C;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic start_request;
      logic start_pulse;
      logic stop_pulse;
      logic general_enable;
      logic remote_select;
      logic jog;
      logic forward_contactor;
      logic reverse_contactor;
      logic external_fault;
      logic external_alarm;
      logic brake_permit;
      logic fault_reset;
      logic load_user_one;
      logic load_user_two;
      logic emergency_mode;
      logic emergency_run;
      logic thermistor_alarm;
      logic thermistor_fault;
   } control_out_t;

   localparam int          CONTROL_W = $bits(control_out_t);

   typedef struct packed {
      logic        level;
      logic        rise;
      logic        fall;
   } input_event_t;

endpackage

// >>> input_sync.sv
// one field input: three-stage synchroniser, debounced level and edge pulses
// assumes the input is asynchronous to i_clock
`timescale 1ns/1ps
module input_sync (
   input  wire logic                          i_clock,
   input  wire logic                          i_rst,
   input  wire logic                          i_clock_enable,
   input  wire logic                          i_pin,
   output input_mapper_pkg::input_event_t     o_event
);
   import input_mapper_pkg::*;

   logic stage1;
   logic stage2;
   logic stage3;

   // ************************************************************
   // synchroniser chain
   // ************************************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else if (i_clock_enable) begin
         stage1 <= i_pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // ************************************************************
   // level and edges, only once stages two and three agree
   // ************************************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_event <= '0;
      end else if (i_clock_enable) begin
         o_event.rise <= (stage2 == stage3) && stage3 && !o_event.level;
         o_event.fall <= (stage2 == stage3) && !stage3 && o_event.level;
         if (stage2 == stage3) begin
            o_event.level <= stage3;
         end
      end
   end

endmodule

// >>> input_mapper.sv
// six-input function mapper with its APB register file
// assumes i_motor_enabled comes from the motor core on the same clock
`timescale 1ns/1ps
module input_mapper (
   input  wire logic                             i_clock,
   input  wire logic                             i_rst,
   input  wire logic                             i_clock_enable,
   input  wire logic [input_mapper_pkg::NUM_INPUTS-1:0] i_control_input,
   input  wire logic                             i_motor_enabled,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [input_mapper_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                      pwdata,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   output input_mapper_pkg::control_out_t        o_control,
   output logic      [input_mapper_pkg::NUM_INPUTS-1:0] o_input_status
);
   import input_mapper_pkg::*;

   // ************************************************************
   // decoding functions
   // ************************************************************

   // reserved codes, and position-private codes on any other input, fall back to no function
   function automatic logic [4:0] effective_code(input int idx, input logic [4:0] code);
      logic [4:0] result;
      result = code;
      if (code > FN_MAX || code == 5'h0D) begin
         result = FN_NONE;
      end else if (code == FN_EMERGENCY && idx != EMERGENCY_INPUT) begin
         result = FN_NONE;
      end else if ((code == FN_THERM_ALARM || code == FN_THERM_FAULT)
                   && idx != THERMISTOR_INPUT) begin
         result = FN_NONE;
      end
      return result;
   endfunction

   // selector word index for an address, NUM_INPUTS when not a selector
   function automatic logic [2:0] selector_index(input logic [ADDR_W-1:0] addr);
      logic [2:0] result;
      result = 3'(NUM_INPUTS);
      if (addr[1:0] == 2'b00 && addr >= REG_SEL_BASE
          && addr < REG_SEL_BASE + 12'(4 * NUM_INPUTS)) begin
         result = 3'((addr - REG_SEL_BASE) >> 2);
      end
      return result;
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   input_event_t      events     [NUM_INPUTS];
   logic [4:0]        selector   [NUM_INPUTS];
   logic [4:0]        code       [NUM_INPUTS];
   logic              write_ok;
   control_out_t      next_control;
   logic [31:0]       next_prdata;
   logic              next_error;
   logic [2:0]        setup_index;
   logic              access_done;

   // ************************************************************
   // per-input synchronisers and effective codes
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_INPUTS; g++) begin : g_input
         input_sync u_sync (
            .i_clock        (i_clock),
            .i_rst          (i_rst),
            .i_clock_enable (i_clock_enable),
            .i_pin          (i_control_input[g]),
            .o_event        (events[g])
         );
         assign code[g] = effective_code(g, selector[g]);
      end
   endgenerate

   // ************************************************************
   // function combination
   // ************************************************************
   always_comb begin
      logic have_start3;
      logic have_stop3;
      logic any_start3_rise;
      logic any_stop3_fall;
      logic brake_seen;
      have_start3     = 1'b0;
      have_stop3      = 1'b0;
      any_start3_rise = 1'b0;
      any_stop3_fall  = 1'b0;
      brake_seen      = 1'b0;
      next_control    = '0;
      // unconfigured functions leave the motor free to run
      next_control.general_enable    = 1'b1;
      next_control.brake_permit      = 1'b1;
      next_control.forward_contactor = 1'b1;
      for (int i = 0; i < NUM_INPUTS; i++) begin
         case (code[i])
            FN_NONE: begin
               // status view only
            end
            FN_START_STOP: begin
               next_control.start_request = events[i].level;
            end
            FN_START_3W: begin
               have_start3     = 1'b1;
               any_start3_rise = any_start3_rise | events[i].rise;
            end
            FN_STOP_3W: begin
               have_stop3     = 1'b1;
               any_stop3_fall = any_stop3_fall | events[i].fall;
            end
            FN_GEN_ENABLE: begin
               // open means disable without ramp
               next_control.general_enable = next_control.general_enable
                                             & events[i].level;
            end
            FN_SOURCE: begin
               next_control.remote_select = events[i].level;
            end
            FN_JOG: begin
               next_control.jog = next_control.jog | events[i].level;
            end
            FN_DIRECTION: begin
               next_control.forward_contactor = !events[i].level;
               next_control.reverse_contactor = events[i].level;
            end
            FN_EXT_FAULT: begin
               next_control.external_fault = next_control.external_fault
                                             | !events[i].level;
            end
            FN_EXT_ALARM: begin
               next_control.external_alarm = next_control.external_alarm
                                             | !events[i].level;
            end
            FN_BRAKE: begin
               // any open input wins over every closed one
               if (!brake_seen) begin
                  next_control.brake_permit = events[i].level;
               end else begin
                  next_control.brake_permit = next_control.brake_permit
                                              & events[i].level;
               end
               brake_seen = 1'b1;
            end
            FN_FAULT_RESET: begin
               // only the edge resets, a held button does nothing more
               next_control.fault_reset = next_control.fault_reset
                                          | events[i].rise;
            end
            FN_LOAD_USER: begin
               if (!i_motor_enabled) begin
                  next_control.load_user_one = next_control.load_user_one
                                               | events[i].rise;
                  next_control.load_user_two = next_control.load_user_two
                                               | events[i].fall;
               end
            end
            FN_EMERGENCY: begin
               next_control.emergency_mode = 1'b1;
               next_control.emergency_run  = events[i].level;
            end
            FN_THERM_ALARM: begin
               // open input means thermistor resistance above trip
               next_control.thermistor_alarm = !events[i].level;
            end
            FN_THERM_FAULT: begin
               next_control.thermistor_fault = !events[i].level;
            end
            default: begin
            end
         endcase
      end
      // a lone three-wire button is ignored, the pair must exist
      next_control.start_pulse = have_start3 & have_stop3 & any_start3_rise;
      next_control.stop_pulse  = have_start3 & have_stop3 & any_stop3_fall;
   end

   // ************************************************************
   // registered control outputs and status view
   // ************************************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_control <= '0;
      end else if (i_clock_enable) begin
         o_control <= next_control;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_input_status <= '0;
      end else if (i_clock_enable) begin
         for (int i = 0; i < NUM_INPUTS; i++) begin
            o_input_status[i] <= events[i].level;
         end
      end
   end

   // ************************************************************
   // APB slave: answer prepared in setup, one access cycle
   // ************************************************************
   assign setup_index = selector_index(paddr);
   assign access_done = psel && penable && pready;

   always_comb begin
      next_prdata = 32'h0000_0000;
      next_error  = 1'b0;
      if (setup_index < 3'(NUM_INPUTS)) begin
         next_prdata = {27'h000_0000, selector[setup_index]};
         // selectors are locked while the motor runs
         if (pwrite && (i_motor_enabled || pwdata > 32'(FN_MAX))) begin
            next_error = 1'b1;
         end
      end else if (paddr == REG_INPUT_STAT) begin
         next_prdata = {26'h000_0000, o_input_status};
         next_error  = pwrite;
      end else if (paddr == REG_FUNC_STAT) begin
         next_prdata = {14'h0000, o_control};
         next_error  = pwrite;
      end else begin
         next_error = 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         prdata   <= 32'h0000_0000;
         write_ok <= 1'b0;
      end else if (i_clock_enable) begin
         if (psel && !penable && !pready) begin
            pready   <= 1'b1;
            pslverr  <= next_error;
            prdata   <= pwrite ? 32'h0000_0000 : next_prdata;
            write_ok <= pwrite && !next_error;
         end else if (access_done) begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0000_0000;
            write_ok <= 1'b0;
         end
      end
   end

   // ************************************************************
   // function selectors
   // ************************************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < NUM_INPUTS; i++) begin
            selector[i] <= SEL_RESET[i];
         end
      end else if (i_clock_enable) begin
         if (access_done && write_ok && setup_index < 3'(NUM_INPUTS)) begin
            selector[setup_index] <= pwdata[4:0];
         end
      end
   end

endmodule

// >>> field_switches.sv
// far-side model: field switches and the motor thermistor on the sixth input
// assumes the bench sets switch levels just after a rising clock edge
`timescale 1ns/1ps
module field_switches (
   input  wire logic [5:0] i_closed,
   input  wire logic       i_therm_trip,
   output logic      [5:0] o_pins
);
   // a tripped thermistor reads as an open sixth input, whatever its switch says
   assign o_pins = {i_closed[5] & ~i_therm_trip, i_closed[4:0]};
endmodule

// >>> input_mapper_asserts.sv
// port checker for the input mapper
// assumes bind onto input_mapper and a single clock domain
`timescale 1ns/1ps
module input_mapper_asserts (
   input wire logic                                    i_clock,
   input wire logic                                    i_rst,
   input wire logic                                    i_clock_enable,
   input wire logic [input_mapper_pkg::NUM_INPUTS-1:0] i_control_input,
   input wire logic                                    i_motor_enabled,
   input wire logic                                    psel,
   input wire logic                                    penable,
   input wire logic [31:0]                             prdata,
   input wire logic                                    pready,
   input wire logic                                    pslverr,
   input wire input_mapper_pkg::control_out_t          o_control,
   input wire logic [input_mapper_pkg::NUM_INPUTS-1:0] o_input_status
);
   import input_mapper_pkg::*;
   logic [3:0] run_count;
   // status latency only holds after the sync chain has refilled
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) run_count <= 4'h0;
      else if (!i_clock_enable) run_count <= 4'h0;
      else if (run_count != 4'h8) run_count <= run_count + 4'h1;
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   a_status_tracks_pin: assert property (
      run_count == 4'h8 |-> o_input_status == $past(i_control_input, 5))
      else $error("input status lags pins wrongly");
   a_apb_wait_free: assert property (
      (psel && !penable && i_clock_enable) ##1 i_clock_enable |-> pready)
      else $error("no ready in first access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_fault_reset_once: assert property (
      o_control.fault_reset |=> !o_control.fault_reset)
      else $error("fault reset pulse too long");
   a_load_blocked: assert property (
      i_motor_enabled [*3] |-> !(o_control.load_user_one || o_control.load_user_two))
      else $error("user load while motor enabled");
   a_contactor_excl: assert property (
      !(o_control.forward_contactor && o_control.reverse_contactor))
      else $error("both contactors closed");
   a_emerg_run_mode: assert property (
      o_control.emergency_run |-> o_control.emergency_mode)
      else $error("emergency run without mode");
   a_therm_excl: assert property (
      !(o_control.thermistor_alarm && o_control.thermistor_fault))
      else $error("thermistor alarm and fault together");
   c_fault_reset: cover property (o_control.fault_reset);
   c_refused: cover property (pready && pslverr);
   c_load_two: cover property (o_control.load_user_two);
endmodule
bind input_mapper input_mapper_asserts chk (
   .i_clock(i_clock), .i_rst(i_rst), .i_clock_enable(i_clock_enable),
   .i_control_input(i_control_input), .i_motor_enabled(i_motor_enabled),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .o_control(o_control), .o_input_status(o_input_status));

// >>> input_mapper_tb.sv
// self-checking bench for the input mapper: APB master plus field switches
// assumes one 200 MHz clock; pins settle 5 edges after a change
`timescale 1ns/1ps
module input_mapper_tb;
   import input_mapper_pkg::*;
   logic         i_clock, i_rst, i_motor_enabled, psel, penable, pwrite, clock_enable;
   logic         pready, pslverr, therm_trip, err;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic [5:0]   closed, pins, o_input_status;
   control_out_t o_control;
   int           mismatches, compares, cnt[5];
   logic [4:0]   codes [8] = '{5'h01, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A};
   logic [1:0]   exp_open [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0};
   logic [1:0]   exp_shut [8] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h0, 2'h0, 2'h2};

   field_switches sw (.i_closed(closed), .i_therm_trip(therm_trip), .o_pins(pins));
   input_mapper uut (.i_clock(i_clock), .i_rst(i_rst), .i_clock_enable(clock_enable),
      .i_control_input(pins), .i_motor_enabled(i_motor_enabled), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_control(o_control),
      .o_input_status(o_input_status));

   always #2.5 i_clock = ~i_clock;

   // ************************************************************
   // tasks
   // ************************************************************
   task wrap_up;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int k;
      @(posedge i_clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge i_clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (k >= 20) begin
         mismatches++;
         wrap_up;
      end
   endtask
   task sel(input int idx, input logic [4:0] code, input logic exp_err);
      apb(1'b1, REG_SEL_BASE + 12'(4 * idx), {27'h0, code}, rd, err);
      check(err, exp_err);
   endtask
   // counts pulses over long enough a window to cover the pin latency
   task settle;
      cnt = '{default: 0};
      repeat (8) begin
         @(posedge i_clock);
         cnt[0] += o_control.start_pulse;
         cnt[1] += o_control.stop_pulse;
         cnt[2] += o_control.fault_reset;
         cnt[3] += o_control.load_user_one;
         cnt[4] += o_control.load_user_two;
      end
   endtask
   task pin(input int idx, input logic v);
      @(posedge i_clock);
      closed[idx] <= v;
      settle;
   endtask
   function automatic logic [1:0] pick(control_out_t c, logic [4:0] code);
      case (code)
         FN_START_STOP: return {c.start_request, 1'b0};
         FN_GEN_ENABLE: return {c.general_enable, 1'b0};
         FN_SOURCE:     return {c.remote_select, 1'b0};
         FN_JOG:        return {c.jog, 1'b0};
         FN_DIRECTION:  return {c.forward_contactor, c.reverse_contactor};
         FN_EXT_FAULT:  return {c.external_fault, 1'b0};
         FN_EXT_ALARM:  return {c.external_alarm, 1'b0};
         default:       return {c.brake_permit, 1'b0};
      endcase
   endfunction

   // ************************************************************
   // sequence
   // ************************************************************
   initial begin
      i_clock = 1'b0; i_rst = 1'b1; i_motor_enabled = 1'b0; psel = 1'b0;
      penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      closed = 6'h00; therm_trip = 1'b0; mismatches = 0; compares = 0;
      clock_enable = 1'b1;
      repeat (5) @(posedge i_clock);
      i_rst <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         apb(1'b0, REG_SEL_BASE + 12'(4 * k), 32'h0, rd, err);
         check(rd, {27'h0, SEL_RESET[k]});
      end
      apb(1'b0, 12'h020, 32'h0, rd, err);
      check(err, 1'b1);
      apb(1'b1, REG_INPUT_STAT, 32'h1, rd, err);
      check(err, 1'b1);
      sel(3, 5'h11, 1'b1);
      i_motor_enabled <= 1'b1;
      sel(3, FN_JOG, 1'b1);
      i_motor_enabled <= 1'b0;
      apb(1'b0, REG_SEL_BASE + 12'h00C, 32'h0, rd, err);
      check(rd, 32'h0);
      pin(0, 1'b1);
      check(cnt[0], 1);
      pin(1, 1'b1);
      pin(1, 1'b0);
      check(cnt[1], 1);
      pin(0, 1'b0);
      sel(1, FN_NONE, 1'b0);
      pin(0, 1'b1);
      check(cnt[0], 0);
      for (int k = 0; k < 8; k++) begin
         sel(3, codes[k], 1'b0);
         pin(3, 1'b0);
         check(pick(o_control, codes[k]), exp_open[k]);
         pin(3, 1'b1);
         check(pick(o_control, codes[k]), exp_shut[k]);
      end
      check(o_input_status[3], 1'b1);
      sel(4, FN_BRAKE, 1'b0);
      settle;
      check(o_control.brake_permit, 1'b0);
      sel(3, FN_JOG, 1'b0);
      sel(4, FN_JOG, 1'b0);
      settle;
      check(o_control.jog, 1'b1);
      sel(3, FN_NONE, 1'b0);
      pin(3, 1'b0);
      check({o_input_status[3], o_control.general_enable}, 2'b01);
      sel(3, FN_FAULT_RESET, 1'b0);
      pin(3, 1'b1);
      check(cnt[2], 1);
      settle;
      check(cnt[2], 0);
      sel(3, FN_LOAD_USER, 1'b0);
      pin(3, 1'b0);
      pin(3, 1'b1);
      check(cnt[3], 1);
      pin(3, 1'b0);
      check(cnt[4], 1);
      i_motor_enabled <= 1'b1;
      pin(3, 1'b1);
      check(cnt[3], 0);
      i_motor_enabled <= 1'b0;
      sel(3, FN_EMERGENCY, 1'b0);
      settle;
      check(o_control.emergency_mode, 1'b0);
      sel(2, FN_EMERGENCY, 1'b0);
      pin(2, 1'b1);
      check({o_control.emergency_mode, o_control.emergency_run}, 2'b11);
      pin(2, 1'b0);
      check({o_control.emergency_mode, o_control.emergency_run}, 2'b10);
      sel(4, FN_THERM_ALARM, 1'b0);
      settle;
      check(o_control.thermistor_alarm, 1'b0);
      sel(5, FN_THERM_ALARM, 1'b0);
      pin(5, 1'b1);
      check(o_control.thermistor_alarm, 1'b0);
      therm_trip <= 1'b1;
      settle;
      check(o_control.thermistor_alarm, 1'b1);
      sel(5, FN_THERM_FAULT, 1'b0);
      settle;
      check({o_control.thermistor_alarm, o_control.thermistor_fault}, 2'b01);
      // frozen clock enable: a pin change must wait for the thaw
      clock_enable <= 1'b0;
      pin(1, 1'b1);
      check(o_input_status[1], 1'b0);
      clock_enable <= 1'b1;
      settle;
      check(o_input_status[1], 1'b1);
      apb(1'b0, REG_INPUT_STAT, 32'h0, rd, err);
      check(rd, 32'h0000_000B);
      apb(1'b0, REG_FUNC_STAT, 32'h0, rd, err);
      check(rd, 32'h0000_4889);
      wrap_up;
   end
endmodule
